// *** bsr_top.sv ***
`timescale 1ns/1ps
`include "bsr_map.svh"
module bsr_top #(
  parameter int PULSE_NS = `BSR_PULSE_NS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic boost_request_pin,
  input wire logic bus_undervoltage,
  input wire logic battery_low,
  input wire logic vin_good,
  input wire logic batfet_detect,
  input wire logic ntc_detect,
  input wire logic [3:0] charge_state,
  input wire logic [7:0] stat_event,
  output logic converter_on,
  output logic input_pass_switch,
  output logic interrupt_pin_n,
  output logic status_pin
);
  localparam int PULSE_CYC = (PULSE_NS + `BSR_CLK_NS - 1) / `BSR_CLK_NS;

  bsr_if lnk ();
  bsr_pkg::bsr_core_t q;
  bsr_pkg::bsr_core_t n;
  bsr_pkg::bsr_core_t rst_val;
  logic [15:0] sync_in;
  logic [15:0] sync_out;
  logic ntc_s, batfet_s, req_s, bus_uv_s, bat_low_s, vin_s, wr_s, rd_s;
  logic [7:0] ptr_bin;
  logic enable;
  logic wr_fire;
  logic rd_fire;
  logic oc_ev;
  logic bl_ev;
  logic sc_ev;
  logic [7:0] status_byte;
  logic [7:0] bst_set;
  logic pend_any;

  bsr_link u_link (
    .scl(scl),
    .rst(rst),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .lnk(lnk.link)
  );

  // pins and link toggles cross into mclk
  assign sync_in = {lnk.ptr_g, lnk.rd_tgl, lnk.wr_tgl, vin_good,
    battery_low, bus_undervoltage, boost_request_pin, batfet_detect,
    ntc_detect};

  bsr_sync #(.WIDTH(16)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .din(sync_in),
    .dout(sync_out)
  );

  assign {rd_s, wr_s, vin_s, bat_low_s, bus_uv_s, req_s, batfet_s, ntc_s} =
    sync_out[7:0];
  assign ptr_bin = bsr_pkg::gray2bin(sync_out[15:8]);

  // register values after any reset
  always_comb
  begin
    rst_val = '0;
    rst_val.boost = bsr_pkg::BST_OFF;
    rst_val.primary_control = `BSR_PRIMARY_CONTROL_RST;
    rst_val.ctrl2 = `BSR_CTRL2_RST;
    rst_val.boost_event_mask_reg = `BSR_BOOST_EVENT_MASK_REG_RST;
    rst_val.interrupt_pin_n_n = 1'b1;
    rst_val.stat_pin = 1'b1;
  end

  // register read view
  function automatic logic [7:0] read_mux(input logic [7:0] a,
    input bsr_pkg::bsr_core_t s, input logic [7:0] st);
    read_mux = 8'h00;
    if (a == `BSR_REG_STATUS)
      read_mux = st;
    else if (a == `BSR_REG_PRIMARY_CONTROL)
      read_mux = s.primary_control;
    else if (a == `BSR_REG_CTRL2)
      read_mux = s.ctrl2;
    else if (a == `BSR_REG_STAT_INT)
      read_mux = s.stat_int;
    else if (a == `BSR_REG_CHG_A || a == `BSR_REG_CHG_B)
      read_mux = `BSR_CHG_RST;
    else if (a == `BSR_REG_BOOST_EVENT_REG)
      read_mux = s.boost_event_reg;
    else if (a == `BSR_REG_BOOST_EVENT_MASK_REG)
      read_mux = s.boost_event_mask_reg;
  endfunction

  // state code, charge code outside boost
  assign status_byte = {(q.boost == bsr_pkg::BST_OFF) ? charge_state : q.boost,
    batfet_s, ntc_s, |q.stat_int, |q.boost_event_reg};

  assign enable = q.primary_control[`BSR_C1_BOOST_EN] | req_s;
  assign wr_fire = wr_s != q.wr_seen;
  assign rd_fire = rd_s != q.rd_seen;
  assign pend_any = (|q.stat_int) | (|q.boost_event_reg);

  // core next state
  always_comb
  begin
    n = q;
    n.reg_rst = 1'b0;
    n.wr_seen = wr_s;
    n.rd_seen = rd_s;
    oc_ev = 1'b0;
    bl_ev = 1'b0;
    case (q.boost)
      bsr_pkg::BST_OFF:
      begin
        if (enable && !q.lockout)
          n.boost = bsr_pkg::BST_WAIT;
      end
      bsr_pkg::BST_WAIT, bsr_pkg::BST_ON:
      begin
        if (!enable)
          n.boost = bsr_pkg::BST_OFF;
        else if (bat_low_s)
        begin
          n.boost = bsr_pkg::BST_OFF;
          bl_ev = 1'b1;
        end
        else if (q.boost == bsr_pkg::BST_ON && bus_uv_s)
        begin
          n.boost = bsr_pkg::BST_OVLD;
          oc_ev = 1'b1;
        end
        else if (vin_s)
          n.boost = bsr_pkg::BST_ON;
      end
      default:
      begin
        if (!enable)
          n.boost = bsr_pkg::BST_OFF;
      end
    endcase
    // restart only after enable drops once
    if (oc_ev || bl_ev)
      n.lockout = 1'b1;
    else if (!enable)
      n.lockout = 1'b0;
    sc_ev = n.boost != q.boost;
    bst_set = 8'h00;
    bst_set[`BSR_BI_OVERCUR] = oc_ev;
    bst_set[`BSR_BI_BATLOW] = bl_ev;
    bst_set[`BSR_BI_STATE] = sc_ev;
    if (wr_fire)
    begin
      if (lnk.wr_addr == `BSR_REG_PRIMARY_CONTROL)
      begin
        n.primary_control = {1'b0, lnk.wr_data[6:0]};
        n.reg_rst = lnk.wr_data[`BSR_C1_SOFT_RST];
      end
      else if (lnk.wr_addr == `BSR_REG_CTRL2)
        n.ctrl2 = lnk.wr_data;
      else if (lnk.wr_addr == `BSR_REG_BOOST_EVENT_MASK_REG)
        n.boost_event_mask_reg = lnk.wr_data;
    end
    // read clears, a new event still wins
    if (rd_fire && lnk.rd_addr == `BSR_REG_STAT_INT)
      n.stat_int = 8'h00;
    if (rd_fire && lnk.rd_addr == `BSR_REG_BOOST_EVENT_REG)
      n.boost_event_reg = 8'h00;
    // only these two event registers collect
    n.stat_int = n.stat_int | (stat_event & `BSR_STAT_INT_VALID);
    n.boost_event_reg = n.boost_event_reg | (bst_set & `BSR_BOOST_EVENT_REG_VALID);
    // per-source mask on boost events only, low while any unmasked event pending
    n.interrupt_pin_n_n = q.primary_control[`BSR_C1_INT_MASK] ||
      !((|q.stat_int) || (|(q.boost_event_reg & ~q.boost_event_mask_reg)));
    // one pulse when events first appear
    n.pend_prev = pend_any;
    if (pend_any && !q.pend_prev && !q.ctrl2[`BSR_C2_PULSE_MASK])
      n.pulse_cnt = PULSE_CYC[23:0];
    else if (q.pulse_cnt != 24'h000000)
      n.pulse_cnt = q.pulse_cnt - 24'h000001;
    n.stat_pin = n.pulse_cnt == 24'h000000;
    // byte offered to the link at the pointer
    n.rd_data = read_mux(ptr_bin, q, status_byte);
    if (q.reg_rst)
    begin
      n = rst_val;
      n.wr_seen = wr_s;
      n.rd_seen = rd_s;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.boost <= bsr_pkg::BST_OFF;
      q.primary_control <= `BSR_PRIMARY_CONTROL_RST;
      q.ctrl2 <= `BSR_CTRL2_RST;
      q.boost_event_mask_reg <= `BSR_BOOST_EVENT_MASK_REG_RST;
      q.interrupt_pin_n_n <= 1'b1;
      q.stat_pin <= 1'b1;
    end
    else
      q <= n;
  end

  // outputs
  assign lnk.rd_data = q.rd_data;
  assign sda_out = 1'b0;
  assign converter_on = q.boost == bsr_pkg::BST_WAIT ||
    q.boost == bsr_pkg::BST_ON;
  assign input_pass_switch = converter_on;
  assign interrupt_pin_n = q.interrupt_pin_n_n;
  assign status_pin = q.stat_pin;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_soft_req;
    wr_fire && lnk.wr_addr == `BSR_REG_PRIMARY_CONTROL &&
      lnk.wr_data[`BSR_C1_SOFT_RST];
  endsequence

  sequence s_soft_done;
    q.reg_rst ##1 (!q.reg_rst && q.primary_control == `BSR_PRIMARY_CONTROL_RST &&
      q.ctrl2 == `BSR_CTRL2_RST);
  endsequence

  a_overcur_fault: assert property (
    (q.boost == bsr_pkg::BST_ON && bus_uv_s && !bat_low_s && enable &&
      !q.reg_rst) |=> (q.boost == bsr_pkg::BST_OVLD && !converter_on &&
      !input_pass_switch && q.boost_event_reg[`BSR_BI_OVERCUR]))
    else $error("overcurrent response missing");

  a_batlow_stop: assert property (
    (converter_on && bat_low_s && enable && !q.reg_rst) |=>
      (!converter_on && q.boost_event_reg[`BSR_BI_BATLOW] && q.lockout))
    else $error("battery low response missing");

  a_lockout_hold: assert property (
    (q.lockout && enable && q.boost == bsr_pkg::BST_OFF) |=>
      q.boost == bsr_pkg::BST_OFF)
    else $error("boost restarted without toggle");

  a_state_field: assert property (
    (q.boost != bsr_pkg::BST_OFF && ptr_bin == `BSR_REG_STATUS &&
      !q.reg_rst) |=> q.rd_data[7:4] == $past(q.boost))
    else $error("state field wrong");

  a_interrupt_pin_n_global: assert property (
    q.primary_control[`BSR_C1_INT_MASK] |=> interrupt_pin_n)
    else $error("interrupt pin active while masked");

  a_interrupt_pin_n_pending: assert property (
    (!q.primary_control[`BSR_C1_INT_MASK] && (|(q.boost_event_reg & ~q.boost_event_mask_reg)) &&
      !q.reg_rst) |=> !interrupt_pin_n)
    else $error("interrupt pin released while pending");

  a_pulse_width: assert property (
    $fell(status_pin) |-> (!status_pin) [*8])
    else $error("status pulse too short");

  a_pulse_mask: assert property (
    (q.ctrl2[`BSR_C2_PULSE_MASK] && q.pulse_cnt == 24'h000000) |=>
      status_pin)
    else $error("status pulse while masked");

  a_soft_reset: assert property (
    s_soft_req |=> s_soft_done)
    else $error("soft reset incomplete");

  a_read_clear: assert property (
    (rd_fire && lnk.rd_addr == `BSR_REG_BOOST_EVENT_REG && !oc_ev && !bl_ev &&
      !sc_ev && !q.reg_rst) |=> q.boost_event_reg == 8'h00)
    else $error("event register not cleared");
endmodule

// *** bsr_map.svh ***
`ifndef BSR_MAP_SVH
`define BSR_MAP_SVH

// register offsets
`define BSR_REG_STATUS 8'h00
`define BSR_REG_PRIMARY_CONTROL 8'h01
`define BSR_REG_CTRL2 8'h02
`define BSR_REG_STAT_INT 8'h03
`define BSR_REG_CHG_A 8'h04
`define BSR_REG_CHG_B 8'h05
`define BSR_REG_BOOST_EVENT_REG 8'h06
`define BSR_REG_BOOST_EVENT_MASK_REG 8'h07

// primary_control fields
`define BSR_C1_SOFT_RST 7
`define BSR_C1_BOOST_EN 5
`define BSR_C1_INT_MASK 0
// second control fields
`define BSR_C2_PULSE_MASK 3
// boost_event_reg fields
`define BSR_BI_OVERCUR 0
`define BSR_BI_BATLOW 1
`define BSR_BI_STATE 2

// reset values
`define BSR_PRIMARY_CONTROL_RST 8'h51
`define BSR_CTRL2_RST 8'h1E
`define BSR_BOOST_EVENT_MASK_REG_RST 8'h00
`define BSR_CHG_RST 8'h00
// implemented bits of the event registers
`define BSR_STAT_INT_VALID 8'h3D
`define BSR_BOOST_EVENT_REG_VALID 8'h07

// 7-bit target address (write 0x6C, read 0x6D)
`define BSR_I2C_ADDR 7'h36

// timing
`define BSR_CLK_NS 10
`define BSR_PULSE_NS 100000

`endif

// *** bsr_pkg.sv ***
package bsr_pkg;

  typedef enum logic [3:0] {
    BST_OFF = 4'h0,
    BST_WAIT = 4'hC,
    BST_ON = 4'hD,
    BST_OVLD = 4'hF
  } bsr_boost_t;

  typedef enum logic [2:0] {
    LK_IDLE = 3'h0,
    LK_ADDR = 3'h1,
    LK_REG = 3'h2,
    LK_WDATA = 3'h3,
    LK_RDATA = 3'h4
  } bsr_phase_t;

  typedef struct packed {
    bsr_phase_t phase;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] ptr_g;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic wr_tgl;
    logic rd_tgl;
    logic ack;
    logic start_seen;
    logic stop_seen;
  } bsr_link_t;

  typedef struct packed {
    bsr_boost_t boost;
    logic [7:0] primary_control;
    logic [7:0] ctrl2;
    logic [7:0] stat_int;
    logic [7:0] boost_event_reg;
    logic [7:0] boost_event_mask_reg;
    logic [7:0] rd_data;
    logic lockout;
    logic reg_rst;
    logic wr_seen;
    logic rd_seen;
    logic pend_prev;
    logic interrupt_pin_n_n;
    logic stat_pin;
    logic [23:0] pulse_cnt;
  } bsr_core_t;

  function automatic logic [7:0] bin2gray(input logic [7:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  function automatic logic [7:0] gray2bin(input logic [7:0] g);
    logic [7:0] b;
    b[7] = g[7];
    for (int i = 6; i >= 0; i--)
    begin
      b[i] = b[i + 1] ^ g[i];
    end
    gray2bin = b;
  endfunction

endpackage

// *** bsr_if.sv ***
`timescale 1ns/1ps
// link-to-core carrier; toggles mark events, words are held stable
interface bsr_if;
  logic wr_tgl;
  logic rd_tgl;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] ptr_g;
  logic [7:0] rd_data;
  modport link (output wr_tgl, rd_tgl, wr_addr, wr_data, rd_addr, ptr_g,
    input rd_data);
  modport core (input wr_tgl, rd_tgl, wr_addr, wr_data, rd_addr, ptr_g,
    output rd_data);
endinterface

// *** bsr_sync.sv ***
`timescale 1ns/1ps
// two-flop synchroniser bank into the mclk domain
module bsr_sync #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;

  // first stage feeds only the second
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
    end
  end

  assign dout = s2_q;
endmodule

// *** bsr_link.sv ***
`timescale 1ns/1ps
`include "bsr_map.svh"
// i2c target running on the host's scl
module bsr_link (
  input wire logic scl,
  input wire logic rst,
  input wire logic sda_in,
  output logic sda_oe,
  bsr_if.link lnk
);
  bsr_pkg::bsr_link_t q;
  bsr_pkg::bsr_link_t n;
  logic start_tgl_q;
  logic stop_tgl_q;
  logic oe_q;
  logic [7:0] byte_v;
  logic drive;

  // start: sda falls while scl high
  always_ff @(negedge sda_in or posedge rst)
  begin
    if (rst)
      start_tgl_q <= 1'b0;
    else if (scl)
      start_tgl_q <= ~start_tgl_q;
  end

  // stop: sda rises while scl high
  always_ff @(posedge sda_in or posedge rst)
  begin
    if (rst)
      stop_tgl_q <= 1'b0;
    else if (scl)
      stop_tgl_q <= ~stop_tgl_q;
  end

  // bit engine, sampled on rising scl
  always_comb
  begin
    n = q;
    byte_v = {q.sh[6:0], sda_in};
    n.ack = 1'b0;
    n.start_seen = start_tgl_q;
    n.stop_seen = stop_tgl_q;
    if (start_tgl_q != q.start_seen)
    begin
      n.phase = bsr_pkg::LK_ADDR;
      n.cnt = 4'h1;
      n.sh = {7'h00, sda_in};
    end
    else if (stop_tgl_q != q.stop_seen)
    begin
      n.phase = bsr_pkg::LK_IDLE;
      n.cnt = 4'h0;
    end
    else if (q.phase != bsr_pkg::LK_IDLE)
    begin
      n.sh = byte_v;
      n.cnt = (q.cnt == 4'h8) ? 4'h0 : q.cnt + 4'h1;
      if (q.phase == bsr_pkg::LK_RDATA && q.cnt <= 4'h6)
        n.tx = {q.tx[6:0], 1'b0};
      if (q.cnt == 4'h7)
      begin
        case (q.phase)
          bsr_pkg::LK_ADDR:
          begin
            // only the 7-bit address is acked
            if (byte_v[7:1] == `BSR_I2C_ADDR)
            begin
              n.ack = 1'b1;
              n.phase = byte_v[0] ? bsr_pkg::LK_RDATA : bsr_pkg::LK_REG;
            end
            else
              n.phase = bsr_pkg::LK_IDLE;
          end
          bsr_pkg::LK_REG:
          begin
            n.ack = 1'b1;
            n.ptr_g = bsr_pkg::bin2gray(byte_v);
            n.phase = bsr_pkg::LK_WDATA;
          end
          bsr_pkg::LK_WDATA:
          begin
            n.ack = 1'b1;
            n.wr_addr = bsr_pkg::gray2bin(q.ptr_g);
            n.wr_data = byte_v;
            n.wr_tgl = ~q.wr_tgl;
            n.ptr_g = bsr_pkg::bin2gray(bsr_pkg::gray2bin(q.ptr_g) + 8'h01);
          end
          default:
            n.ack = 1'b0;
        endcase
      end
      // read continues from the pointer while acked
      if (q.cnt == 4'h8 && q.phase == bsr_pkg::LK_RDATA)
      begin
        if (!sda_in)
        begin
          n.tx = lnk.rd_data;
          n.rd_addr = bsr_pkg::gray2bin(q.ptr_g);
          n.rd_tgl = ~q.rd_tgl;
          n.ptr_g = bsr_pkg::bin2gray(bsr_pkg::gray2bin(q.ptr_g) + 8'h01);
        end
        else
          n.phase = bsr_pkg::LK_IDLE;
      end
    end
  end

  always_ff @(posedge scl or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= n;
  end

  // sda pulled low for ack or a zero data bit
  assign drive = (q.cnt == 4'h8 && q.ack) ||
    (q.phase == bsr_pkg::LK_RDATA && q.cnt <= 4'h7 && !q.tx[7]);

  // output changes only while scl is low
  always_ff @(negedge scl or posedge rst)
  begin
    if (rst)
      oe_q <= 1'b0;
    else
      oe_q <= drive;
  end

  assign sda_oe = oe_q;
  assign lnk.wr_tgl = q.wr_tgl;
  assign lnk.rd_tgl = q.rd_tgl;
  assign lnk.wr_addr = q.wr_addr;
  assign lnk.wr_data = q.wr_data;
  assign lnk.rd_addr = q.rd_addr;
  assign lnk.ptr_g = q.ptr_g;
endmodule

// *** bsr_i2c_host.sv ***
`timescale 1ns/1ps
// i2c host model; scl stands high between frames, sda pulled up
module bsr_i2c_host (
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // start or repeated start, sda falls while scl high
  task automatic start_c;
    #3 sda_pull = 1'b0;
    #16 scl = 1'b1;
    #16 sda_pull = 1'b1;
    #16 scl = 1'b0;
    #16;
  endtask

  // stop, sda rises while scl high
  task automatic stop_c;
    sda_pull = 1'b1;
    #16 scl = 1'b1;
    #16 sda_pull = 1'b0;
    #32;
  endtask

  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_pull = ~b[i];
      #16 scl = 1'b1;
      #32 scl = 1'b0;
      #16;
    end
    sda_pull = 1'b0;
    #16 scl = 1'b1;
    ack = ~sda;
    #32 scl = 1'b0;
    #16;
  endtask

  // byte in, host acks unless last
  task automatic get(output logic [7:0] b, input logic last);
    sda_pull = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      #16 scl = 1'b1;
      b[i] = sda;
      #32 scl = 1'b0;
      #16;
    end
    sda_pull = ~last;
    #16 scl = 1'b1;
    #32 scl = 1'b0;
    #16;
    sda_pull = 1'b0;
  endtask

  task automatic wr(input logic [7:0] dev, input logic [7:0] ptr,
    input int n, input logic [15:0] d, output logic ok);
    logic a0, a1, a2, a3;
    a2 = 1'b1;
    a3 = 1'b1;
    start_c();
    put(dev, a0);
    put(ptr, a1);
    if (n > 0) put(d[15:8], a2);
    if (n > 1) put(d[7:0], a3);
    stop_c();
    ok = a0 & a1 & a2 & a3;
  endtask

  task automatic rd(input logic [7:0] ptr, input int n,
    output logic [15:0] d, output logic ok);
    logic a0, a1, a2;
    logic [7:0] b0, b1;
    b1 = 8'h00;
    start_c();
    put(8'h6C, a0);
    put(ptr, a1);
    start_c();
    put(8'h6D, a2);
    get(b0, n == 1);
    if (n > 1) get(b1, 1'b1);
    stop_c();
    d = {b0, b1};
    ok = a0 & a1 & a2;
  endtask
endmodule

// *** bsr_top_tb.sv ***
`timescale 1ns/1ps
module bsr_top_tb;
  localparam int PNS = 200;
  localparam int PCYC = PNS / 10;
  logic mclk, rst, scl, sda_pull, sda_out, sda_oe, sda;
  logic boost_request_pin, bus_undervoltage, battery_low, vin_good;
  logic batfet_detect, ntc_detect, converter_on, input_pass_switch;
  logic interrupt_pin_n, status_pin, ok;
  logic [3:0] charge_state;
  logic [7:0] stat_event;
  logic [15:0] d;
  int errors, n_compared, pulses, plen, pw, p0;

  // open-drain sda with pull-up
  assign sda = ~(sda_pull | sda_oe);

  bsr_top #(.PULSE_NS(PNS)) u_bsr_top (.mclk(mclk), .rst(rst), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .boost_request_pin(boost_request_pin),
    .bus_undervoltage(bus_undervoltage), .battery_low(battery_low),
    .vin_good(vin_good), .batfet_detect(batfet_detect),
    .ntc_detect(ntc_detect), .charge_state(charge_state),
    .stat_event(stat_event), .converter_on(converter_on),
    .input_pass_switch(input_pass_switch),
    .interrupt_pin_n(interrupt_pin_n), .status_pin(status_pin));

  bsr_i2c_host u_bsr_i2c_host (.scl(scl), .sda_pull(sda_pull), .sda(sda));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // measures status pin low pulses
  always @(negedge mclk)
  begin
    if (status_pin === 1'b0)
      pw = pw + 1;
    else if (pw != 0)
    begin
      plen = pw;
      pulses = pulses + 1;
      pw = 0;
    end
  end

  task automatic complete_run;
    if (errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] p, input logic [7:0] e);
    u_bsr_i2c_host.rd(p, 1, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d[15:8], e);
    @(negedge mclk);
  endtask

  task automatic wrc(input logic [7:0] p, input logic [7:0] v);
    u_bsr_i2c_host.wr(8'h6C, p, 1, {v, 8'h00}, ok);
    chk({7'h00, ok}, 8'h01);
    @(negedge mclk);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // one status event pulse
  task automatic ev;
    @(negedge mclk) stat_event = 8'h04;
    @(negedge mclk) stat_event = 8'h00;
    cyc(5);
  endtask

  // hang guard
  initial
  begin
    repeat (100000) @(posedge mclk);
    errors++;
    complete_run();
  end

  initial
  begin
    {errors, n_compared, pulses, plen, pw} = '0;
    rst = 1'b1;
    {boost_request_pin, bus_undervoltage, battery_low, vin_good} = 4'h0;
    {batfet_detect, ntc_detect} = 2'h3;
    charge_state = 4'h3;
    stat_event = 8'h00;
    cyc(4);
    rst = 1'b0;
    cyc(5);
    chk({4'h0, sda_oe, sda_out, interrupt_pin_n, status_pin}, 8'h03);
    u_bsr_i2c_host.rd(8'h01, 2, d, ok);
    chk(d[15:8], 8'h51);
    chk(d[7:0], 8'h1E);
    rdc(8'h00, 8'h3C);
    ntc_detect = 1'b0;
    cyc(5);
    rdc(8'h00, 8'h38);
    ntc_detect = 1'b1;
    rdc(8'h04, 8'h00);
    rdc(8'h08, 8'h00);
    u_bsr_i2c_host.wr(8'h6E, 8'h07, 1, 16'h0700, ok);
    chk({7'h00, ok}, 8'h00);
    rdc(8'h07, 8'h00);
    u_bsr_i2c_host.wr(8'h6C, 8'h01, 2, 16'h5016, ok);
    chk({7'h00, ok}, 8'h01);
    u_bsr_i2c_host.rd(8'h01, 2, d, ok);
    chk(d[15:8], 8'h50);
    chk(d[7:0], 8'h16);
    // boost from request pin, then overload
    cyc(1);
    boost_request_pin = 1'b1;
    cyc(10);
    chk({6'h00, converter_on, input_pass_switch}, 8'h03);
    chk({7'h00, interrupt_pin_n}, 8'h00);
    rdc(8'h00, 8'hCD);
    chk(pulses[7:0], 8'h01);
    chk(plen[7:0], PCYC[7:0]);
    vin_good = 1'b1;
    cyc(10);
    rdc(8'h00, 8'hDD);
    bus_undervoltage = 1'b1;
    cyc(10);
    chk({6'h00, converter_on, input_pass_switch}, 8'h00);
    rdc(8'h00, 8'hFD);
    rdc(8'h06, 8'h05);
    rdc(8'h06, 8'h00);
    chk({7'h00, interrupt_pin_n}, 8'h01);
    bus_undervoltage = 1'b0;
    boost_request_pin = 1'b0;
    cyc(10);
    rdc(8'h00, 8'h3D);
    rdc(8'h06, 8'h04);
    chk(pulses[7:0], 8'h02);
    // battery low through enable bit, lockout and toggle
    wrc(8'h01, 8'h70);
    cyc(10);
    chk({7'h00, converter_on}, 8'h01);
    battery_low = 1'b1;
    cyc(10);
    chk({7'h00, converter_on}, 8'h00);
    battery_low = 1'b0;
    cyc(10);
    chk({7'h00, converter_on}, 8'h00);
    rdc(8'h06, 8'h06);
    wrc(8'h01, 8'h50);
    wrc(8'h01, 8'h70);
    cyc(10);
    chk({7'h00, converter_on}, 8'h01);
    rdc(8'h04, 8'h00);
    rdc(8'h05, 8'h00);
    rdc(8'h06, 8'h04);
    // per-source mask, then two pending registers
    wrc(8'h07, 8'h07);
    wrc(8'h01, 8'h50);
    cyc(10);
    chk({7'h00, interrupt_pin_n}, 8'h01);
    ev();
    chk({7'h00, interrupt_pin_n}, 8'h00);
    rdc(8'h00, 8'h3F);
    rdc(8'h03, 8'h04);
    chk({7'h00, interrupt_pin_n}, 8'h01);
    wrc(8'h07, 8'h00);
    ev();
    rdc(8'h03, 8'h04);
    chk({7'h00, interrupt_pin_n}, 8'h00);
    rdc(8'h06, 8'h04);
    chk({7'h00, interrupt_pin_n}, 8'h01);
    // global masks on both pins
    wrc(8'h02, 8'h1E);
    wrc(8'h01, 8'h51);
    p0 = pulses;
    ev();
    cyc(30);
    chk({7'h00, interrupt_pin_n}, 8'h01);
    chk(pulses[7:0], p0[7:0]);
    rdc(8'h03, 8'h04);
    // soft reset
    wrc(8'h02, 8'h16);
    wrc(8'h07, 8'h03);
    wrc(8'h01, 8'hD0);
    u_bsr_i2c_host.rd(8'h01, 2, d, ok);
    chk(d[15:8], 8'h51);
    chk(d[7:0], 8'h1E);
    rdc(8'h07, 8'h00);
    complete_run();
  end
endmodule
